// File: rtl/aisi_defines.svh
// constants for the analog input status indicator block
`ifndef AISI_DEFINES_SVH
`define AISI_DEFINES_SVH
`define AISI_NUM_CH        4
`define AISI_SAMPLE_W      12
`define AISI_CLK_HZ        10000000
`define AISI_FLASH_MS      100
`define AISI_FLASH_CYC     ((`AISI_CLK_HZ / 1000) * `AISI_FLASH_MS)
`define AISI_CNT_W         24
`define AISI_PHASE_W       4
`define AISI_PHASES        10
`define AISI_PAT_FLASH     10'h2aa
`define AISI_PAT_SINGLE    10'h001
`define AISI_PAT_DOUBLE    10'h005
`define AISI_ADDR_STATUS   4'h0
`define AISI_ADDR_MASK     4'h4
`define AISI_ADDR_LAMPS    4'h8
`define AISI_ADDR_SAMPLE0  4'hc
`define AISI_ADDR_SAMPLE1  4'hd
`define AISI_EVT_W         4
`define AISI_EVT_BUS_ERR   0
`define AISI_EVT_CH_ERR    1
`define AISI_EVT_SUPPLY    2
`define AISI_EVT_GEN_ERR   3
`endif

// File: rtl/aisi_pkg.sv
// types for the analog input status indicator block
`default_nettype none
package aisi_pkg;
  typedef enum logic [1:0] {AISI_BUS_OFF, AISI_BUS_PREOP, AISI_BUS_OP, AISI_BUS_ERR} aisi_bus_t;
  typedef enum logic [1:0] {AISI_MOD_OFF, AISI_MOD_RESET, AISI_MOD_PREOP, AISI_MOD_OP} aisi_mod_t;
  typedef struct packed {
    logic open;
    logic over;
    logic under;
    logic conv_ok;
  } aisi_ch_t;
  typedef struct packed {
    logic       bus_green;
    logic       bus_red;
    logic [3:0] ch_green;
    logic       mod_green;
    logic       mod_red;
  } aisi_lamps_t;
endpackage
`default_nettype wire

// File: rtl/aisi_top.sv
// status lamp driver and sample/event registers for a four channel input module
//
// Function
// - bus lamp pair green and red, both dark without bus supply
// - bus powered but not initialized: both bus lamps steadily lit
// - bus operational: green lit, red dark
// - bus error: green dark, red lit
// - one green lamp per channel, driven only by its own channel
// - channel lamp dark on open input or disconnected sensor
// - channel lamp flashes on overflow or underflow
// - channel lamp steady when converter runs and value is valid
// - green module lamp: dark, single flash, flashing, steady by state
// - red module lamp single flash on any channel error
// - red module lamp double flash while supply out of range
// - red module lamp steady in reset or general error unless module off, else dark
// - four channels, each sample eleven magnitude bits plus sign
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`include "aisi_defines.svh"
`default_nettype none
module aisi_top #(
  parameter int unsigned FLASH_CYC = `AISI_FLASH_CYC
) (
  input  wire logic                                   clk,
  input  wire logic                                   rst_b,
  input  wire aisi_pkg::aisi_bus_t                    bus_state,
  input  wire aisi_pkg::aisi_mod_t                    mod_state,
  input  wire logic                                   gen_err,
  input  wire logic                                   supply_bad,
  input  wire aisi_pkg::aisi_ch_t [`AISI_NUM_CH-1:0]  ch_flags,
  input  wire logic [`AISI_NUM_CH*`AISI_SAMPLE_W-1:0] ch_sample,
  input  wire logic                                   ch_sample_vld,
  input  wire logic [3:0]                             addr,
  input  wire logic [31:0]                            wdata,
  input  wire logic                                   wr,
  input  wire logic                                   rd,
  output logic [31:0]                                 rdata,
  output logic                                        irq,
  output aisi_pkg::aisi_lamps_t                       lamps
);
  import aisi_pkg::*;

  typedef struct packed {
    logic [`AISI_CNT_W-1:0]                 div;
    logic [`AISI_PHASE_W-1:0]               phase;
    aisi_lamps_t                            lamps;
    logic [`AISI_NUM_CH*`AISI_SAMPLE_W-1:0] sample;
    logic [`AISI_EVT_W-1:0]                 status;
    logic [`AISI_EVT_W-1:0]                 mask;
    logic [31:0]                            rdata;
    logic [`AISI_EVT_W-1:0]                 ev_prev;
  } aisi_state_t;

  aisi_state_t st;
  aisi_state_t next_st;

  logic                    tick;
  logic                    pat_flash;
  logic                    pat_single;
  logic                    pat_double;
  logic [`AISI_NUM_CH-1:0] ch_err;
  logic [`AISI_NUM_CH-1:0] ch_lit;
  logic [`AISI_EVT_W-1:0]  ev_now;
  logic                    status_clr;
  logic [`AISI_EVT_W-1:0]  next_status;

  // ten phases per pattern frame; single = one pulse, double = two
  aisi_pattern #(.ON_MASK(`AISI_PAT_FLASH)) i_aisi_pattern_flash (
    .phase (st.phase),
    .lit   (pat_flash)
  );
  aisi_pattern #(.ON_MASK(`AISI_PAT_SINGLE)) i_aisi_pattern_single (
    .phase (st.phase),
    .lit   (pat_single)
  );
  aisi_pattern #(.ON_MASK(`AISI_PAT_DOUBLE)) i_aisi_pattern_double (
    .phase (st.phase),
    .lit   (pat_double)
  );

  // each lamp sees only the flags of its own channel
  for (genvar g = 0; g < `AISI_NUM_CH; g++)
  begin : gen_ch
    aisi_ch_lamp i_aisi_ch_lamp (
      .flags (ch_flags[g]),
      .flash (pat_flash),
      .err   (ch_err[g]),
      .lit   (ch_lit[g])
    );
  end

  // one sticky bit per event; a status read clears them all
  for (genvar e = 0; e < `AISI_EVT_W; e++)
  begin : gen_evt
    aisi_evt_bit i_aisi_evt_bit (
      .evt       (ev_now[e]),
      .evt_prev  (st.ev_prev[e]),
      .held      (st.status[e]),
      .clr       (status_clr),
      .next_held (next_status[e])
    );
  end

  always_comb
  begin
    tick       = (st.div == `AISI_CNT_W'(FLASH_CYC - 1));
    status_clr = rd && (addr == `AISI_ADDR_STATUS);
    // levels here; the status bits keep only their rising edges
    ev_now = '0;
    ev_now[`AISI_EVT_BUS_ERR] = (bus_state == AISI_BUS_ERR);
    ev_now[`AISI_EVT_CH_ERR]  = |ch_err;
    ev_now[`AISI_EVT_SUPPLY]  = supply_bad;
    ev_now[`AISI_EVT_GEN_ERR] = gen_err;
  end

  always_comb
  begin
    next_st = st;
    next_st.ev_prev = ev_now;
    next_st.div = tick ? '0 : st.div + `AISI_CNT_W'(1);
    if (tick)
    begin
      if (st.phase == `AISI_PHASE_W'(`AISI_PHASES - 1))
      begin
        next_st.phase = '0;
      end
      else
      begin
        next_st.phase = st.phase + `AISI_PHASE_W'(1);
      end
    end

    case (bus_state)
      AISI_BUS_OFF:
      begin
        next_st.lamps.bus_green = 1'b0;
        next_st.lamps.bus_red   = 1'b0;
      end
      AISI_BUS_PREOP:
      begin
        next_st.lamps.bus_green = 1'b1;
        next_st.lamps.bus_red   = 1'b1;
      end
      AISI_BUS_OP:
      begin
        next_st.lamps.bus_green = 1'b1;
        next_st.lamps.bus_red   = 1'b0;
      end
      AISI_BUS_ERR:
      begin
        next_st.lamps.bus_green = 1'b0;
        next_st.lamps.bus_red   = 1'b1;
      end
      default:
      begin
        next_st.lamps.bus_green = 1'b0;
        next_st.lamps.bus_red   = 1'b0;
      end
    endcase

    next_st.lamps.ch_green = ch_lit;

    case (mod_state)
      AISI_MOD_OFF:   next_st.lamps.mod_green = 1'b0;
      AISI_MOD_RESET: next_st.lamps.mod_green = pat_single;
      AISI_MOD_PREOP: next_st.lamps.mod_green = pat_flash;
      AISI_MOD_OP:    next_st.lamps.mod_green = 1'b1;
      default:        next_st.lamps.mod_green = 1'b0;
    endcase

    // steady error outranks patterns; supply fault outranks channel fault
    if (mod_state == AISI_MOD_OFF)
    begin
      next_st.lamps.mod_red = 1'b0;
    end
    else if (mod_state == AISI_MOD_RESET || gen_err)
    begin
      next_st.lamps.mod_red = 1'b1;
    end
    else if (supply_bad)
    begin
      next_st.lamps.mod_red = pat_double;
    end
    else if (|ch_err)
    begin
      next_st.lamps.mod_red = pat_single;
    end
    else
    begin
      next_st.lamps.mod_red = 1'b0;
    end

    // held until the next strobe; no second buffer behind it
    if (ch_sample_vld)
    begin
      next_st.sample = ch_sample;
    end

    next_st.rdata = '0;
    if (rd)
    begin
      case (addr)
        `AISI_ADDR_STATUS: next_st.rdata = 32'(st.status);
        `AISI_ADDR_MASK:   next_st.rdata = 32'(st.mask);
        `AISI_ADDR_LAMPS:  next_st.rdata = 32'(st.lamps);
        `AISI_ADDR_SAMPLE0:
        begin
          next_st.rdata = {st.sample[2*`AISI_SAMPLE_W+7:2*`AISI_SAMPLE_W],
                           st.sample[2*`AISI_SAMPLE_W-1:0]} ;
        end
        `AISI_ADDR_SAMPLE1:
        begin
          next_st.rdata = 32'(st.sample[4*`AISI_SAMPLE_W-1:2*`AISI_SAMPLE_W+8]);
        end
        default:           next_st.rdata = '0;
      endcase
    end
    next_st.status = next_status;
    if (wr && addr == `AISI_ADDR_MASK)
    begin
      next_st.mask = wdata[`AISI_EVT_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign irq   = |(st.status & st.mask);
  assign lamps = st.lamps;
endmodule

// one channel lamp: off on an open input, flashing on a range fault
module aisi_ch_lamp (
  input  wire aisi_pkg::aisi_ch_t flags,
  input  wire logic               flash,
  output logic                    err,
  output logic                    lit
);
  import aisi_pkg::*;

  // open wins over range faults: a floating input often reads as full scale
  always_comb
  begin
    err = flags.open || flags.over || flags.under;
    if (flags.open)
    begin
      lit = 1'b0;
    end
    else if (flags.over || flags.under)
    begin
      lit = flash;
    end
    else
    begin
      lit = flags.conv_ok;
    end
  end
endmodule

// one blink pattern: one mask bit per phase of the frame
module aisi_pattern #(
  parameter logic [`AISI_PHASES-1:0] ON_MASK = '0
) (
  input  wire logic [`AISI_PHASE_W-1:0] phase,
  output logic                          lit
);
  import aisi_pkg::*;

  // the phase counter wraps at the frame end; anything past it reads dark
  always_comb
  begin
    if (phase < `AISI_PHASE_W'(`AISI_PHASES))
    begin
      lit = ON_MASK[phase];
    end
    else
    begin
      lit = 1'b0;
    end
  end
endmodule

// one sticky status bit: set by a rising event, cleared by a status read
module aisi_evt_bit (
  input  wire logic evt,
  input  wire logic evt_prev,
  input  wire logic held,
  input  wire logic clr,
  output logic      next_held
);
  import aisi_pkg::*;

  logic rise;

  // set wins over a clear in the same cycle, so no event is lost
  always_comb
  begin
    rise      = evt && !evt_prev;
    next_held = rise || (held && !clr);
  end
endmodule
`default_nettype wire

// File: verification/aisi_top_properties.sv
// concurrent checks on the status lamp outputs
`include "aisi_defines.svh"
`default_nettype none
module aisi_top_properties #(
  parameter int unsigned FLASH_CYC = 4
) (
  input wire logic                                  clk,
  input wire logic                                  rst_b,
  input wire aisi_pkg::aisi_bus_t                   bus_state,
  input wire aisi_pkg::aisi_mod_t                   mod_state,
  input wire aisi_pkg::aisi_ch_t [`AISI_NUM_CH-1:0] ch_flags,
  input wire aisi_pkg::aisi_lamps_t                 lamps
);
  timeunit 1ns;
  timeprecision 1ns;
  import aisi_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // lamps lag their inputs by one edge, so causes are one cycle back
  a_bus_off_dark: assert property ($past(rst_b) && $past(bus_state) == AISI_BUS_OFF
    |-> !lamps.bus_green && !lamps.bus_red) else $error("bus lamps lit without supply");
  a_bus_preop_both: assert property (bus_state == AISI_BUS_PREOP
    |=> lamps.bus_green && lamps.bus_red) else $error("bus lamps not both lit");
  a_bus_op_green: assert property (bus_state == AISI_BUS_OP [*2]
    |-> lamps.bus_green && !lamps.bus_red) else $error("bus lamps wrong when running");
  a_bus_err_red: assert property ($rose(bus_state == AISI_BUS_ERR)
    |=> !lamps.bus_green && lamps.bus_red) else $error("bus lamps wrong on bus error");
  a_chan_open_dark: assert property (ch_flags[1].open [*2]
    |-> !lamps.ch_green[1]) else $error("channel lamp lit on open input");
  a_chan_ok_lit: assert property (ch_flags[3] == 4'h1
    |=> lamps.ch_green[3]) else $error("channel lamp dark with valid value");
  a_mod_op_green: assert property (mod_state == AISI_MOD_OP
    |=> lamps.mod_green) else $error("module lamp dark when operational");
  a_mod_off_dark: assert property ($past(rst_b) && $past(mod_state) == AISI_MOD_OFF
    |-> !lamps.mod_green && !lamps.mod_red) else $error("module lamps lit without supply");
endmodule
`default_nettype wire

// File: verification/aisi_lamp_panel.sv
// front panel model: counts lit cycles of one selected lamp
`default_nettype none
module aisi_lamp_panel (
  input  wire logic                  clk,
  input  wire logic                  clr,
  input  wire logic [2:0]            sel,
  input  wire aisi_pkg::aisi_lamps_t lamps,
  output logic [7:0]                 lit
);
  timeunit 1ns;
  timeprecision 1ns;
  import aisi_pkg::*;
  logic [7:0] v;
  assign v = lamps;
  always_ff @(posedge clk)
    if (clr)
      lit <= 8'h0;
    else
      lit <= lit + {7'h0, v[sel]};
endmodule
`default_nettype wire

// File: verification/tb.sv
// self-checking testbench for the status lamp block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import aisi_pkg::*;
  logic           clk = 0, rst_b = 0, gen_err = 0, supply_bad = 0, vld = 0, wr = 0, rd = 0;
  logic           clr = 0;
  aisi_bus_t      bus_state = AISI_BUS_OFF;
  aisi_mod_t      mod_state = AISI_MOD_OFF;
  aisi_ch_t [3:0] ch_flags = '0;
  logic [47:0]    ch_sample = '0;
  logic [3:0]     addr = '0;
  logic [31:0]    wdata = '0, rdata;
  logic [2:0]     sel = '0;
  logic [7:0]     lit;
  logic           irq;
  aisi_lamps_t    lamps;
  int             num_errors = 0, comparisons = 0;
  initial forever #50 clk = ~clk;
  aisi_top #(.FLASH_CYC(4)) i_aisi_top (.clk, .rst_b, .bus_state, .mod_state, .gen_err,
    .supply_bad, .ch_flags, .ch_sample, .ch_sample_vld(vld), .addr, .wdata, .wr, .rd,
    .rdata, .irq, .lamps);
  aisi_lamp_panel i_aisi_lamp_panel (.clk, .clr, .sel, .lamps, .lit);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one frame is ten phases of four cycles, so any 40 cycles hold one frame
  task automatic frame(input logic [2:0] s, input logic [7:0] exp);
    sel <= s;
    repeat (3) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (41) @(posedge clk);
    chk(lit, exp);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk(rdata, exp);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic t_bus;
    logic [1:0] exp [4] = '{2'b00, 2'b11, 2'b10, 2'b01};
    for (int i = 0; i < 4; i++)
    begin
      bus_state <= aisi_bus_t'(i);
      repeat (3) @(posedge clk);
      chk({lamps.bus_green, lamps.bus_red}, exp[i]);
    end
    $display("t_bus done");
  endtask
  task automatic t_chan;
    ch_flags <= 16'h12c4;
    frame(3'd2, 8'd20);
    frame(3'd3, 8'd0);
    frame(3'd4, 8'd20);
    frame(3'd5, 8'd40);
    $display("t_chan done");
  endtask
  task automatic t_mod;
    logic [7:0] g [4] = '{8'd0, 8'd4, 8'd20, 8'd40};
    logic [7:0] r [4] = '{8'd0, 8'd40, 8'd0, 8'd0};
    ch_flags <= 16'h1111;
    for (int i = 0; i < 4; i++)
    begin
      mod_state <= aisi_mod_t'(i);
      frame(3'd1, g[i]);
      frame(3'd0, r[i]);
    end
    $display("t_mod done");
  endtask
  task automatic t_red;
    supply_bad <= 1'b1;
    frame(3'd0, 8'd8);
    supply_bad <= 1'b0;
    ch_flags <= 16'h1118;
    frame(3'd0, 8'd4);
    gen_err <= 1'b1;
    frame(3'd0, 8'd40);
    gen_err <= 1'b0;
    ch_flags <= 16'h1111;
    $display("t_red done");
  endtask
  task automatic t_regs;
    chk(irq, 1'b0);
    rd_chk(4'h0, 32'hf);
    rd_chk(4'h0, 32'h0);
    rd_chk(4'h8, 32'h7e);
    wr_reg(4'h4, 32'h4);
    supply_bad <= 1'b1;
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    wr_reg(4'h8, 32'hf);
    rd_chk(4'h4, 32'h4);
    rd_chk(4'h0, 32'h4);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    gen_err <= 1'b1;
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    rd_chk(4'h0, 32'h8);
    rd_chk(4'h2, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_sample;
    ch_sample <= 48'h123ab67f19c4;
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    rd_chk(4'hc, 32'hb67f19c4);
    rd_chk(4'hd, 32'h123a);
    $display("t_sample done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    chk(lamps, 8'h0);
    rst_b <= 1'b1;
    @(posedge clk);
    t_bus;
    t_chan;
    t_mod;
    t_red;
    t_regs;
    t_sample;
    tally_and_finish;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    tally_and_finish;
  end
endmodule
bind aisi_top aisi_top_properties #(.FLASH_CYC(FLASH_CYC)) i_aisi_top_properties (.clk, .rst_b,
  .bus_state, .mod_state, .ch_flags, .lamps);
`default_nettype wire
